// [include/fault_pkg.sv]
// Shared constants and carrier types for the LED driver fault supervisor
package fault_pkg;
    localparam int unsigned CLK_HZ = 50_000_000;
    localparam int unsigned STRINGS = 6;
    // Quiet time on enable or dimming input before sleep or fault clear, in microseconds
    localparam int unsigned QUIET_TIME_US = 16_000;
    localparam int unsigned QUIET_CYCLES = (CLK_HZ / 1_000_000) * QUIET_TIME_US;
    // Switching cycles the shared fault line must stay low before all-off acts
    localparam int unsigned EXT_FAULT_SW_CYCLES = 8;
    localparam logic [5:0] SINK_ALL_ON = 6'h3f;

    // Analog comparator results per string
    typedef struct packed {
        logic [STRINGS-1:0] above_short;  // Sink pin above short_detect_threshold
        logic [STRINGS-1:0] in_regulation; // Sink pin below regulation level
    } sink_sense_t;

    // Power state
    typedef enum logic [1:0] {
        ST_SLEEP = 2'b00,
        ST_IDLE = 2'b01,
        ST_SOFT_START = 2'b10,
        ST_RUN = 2'b11
    } power_state_t;
endpackage

// [design/fault_shutdown.sv]
// Fault supervision and shutdown sequencing for a six-string LED driver
// Functional notes
// RULE1: Enable low 16 ms enters sleep
// RULE2: Enable high after sleep clears faults, soft-starts
// RULE3: Dimming low 16 ms clears faults, stays awake
// RULE4: Bias and sync clock active while enabled
// RULE5: Fault indicator is open-drain, pulls low
// RULE6: All-off: external fault 8 cycles disables all
// RULE7: Sink above short threshold leaves regulation
// RULE8: Standard: only shorted string off, fault latched
// RULE9: All-off: any partial short turns all off
// RULE10: Short detect armed only if one regulating
// RULE11: Quiet timers restart when input returns high
module fault_shutdown #(
    parameter int unsigned QUIET_COUNT = fault_pkg::QUIET_CYCLES,
    parameter bit ALL_OFF_VARIANT = 1'b0
) (
    // Clock and reset (clk runs at CLK_HZ; switch_tick marks each boost switching cycle)
    input wire logic clk,
    input wire logic arst_n,
    // Control pins
    input wire logic enable_pin,
    input wire logic dim_pulse_pin,
    input wire logic switch_tick,
    // Sink comparators
    input wire fault_pkg::sink_sense_t sink_sense,
    // Shared fault line
    input wire logic fault_line_in,
    output logic fault_line_out,
    output logic fault_line_oe_n,
    // Power controls
    output logic bias_supply_on,
    output logic sync_clock_enable,
    output logic boost_enable,
    output logic soft_start_req,
    output logic [fault_pkg::STRINGS-1:0] sink_enable,
    output fault_pkg::power_state_t power_state
);
    import fault_pkg::*;

    // Latency summary, counted in clk edges from a pin change:
    // - two edges through the synchronisers before any logic sees it,
    // - one edge for the state or latch that reacts,
    // - one edge more for the registered output.
    // The shared fault line is sensed through the same synchroniser, so a
    // peer's pull-down is seen a little late; the all-off threshold counts
    // switching ticks, which makes that lag small next to the 8-tick window.
    // Latches in this block all let a set win over a clear in the same
    // cycle, so a fault that appears exactly as the quiet timer expires is
    // reported rather than lost.
    // Nothing here depends on the analog levels themselves; comparators
    // outside hand over one bit per string and per threshold.

    // Counter width covers the full quiet count
    localparam int unsigned QW = $clog2(QUIET_COUNT + 1);
    localparam logic [QW-1:0] QUIET_LAST = QW'(QUIET_COUNT - 1);
    // Quiet counters saturate at their last value, so each expiry pulse
    // fires once per quiet interval and cannot wrap into a second event
    // while a pin sits low for much longer than the interval.

    // Synchronised pins and quiet timers
    logic en_s1_q, en_q, dim_s1_q, dim_q, fl_s1_q, fl_q;
    logic [STRINGS-1:0] sh_s1_q, sh_q, rg_s1_q, rg_q;
    logic [QW-1:0] en_low_cnt_q, dim_low_cnt_q;
    logic sleep_evt, clear_evt, dim_rise, dim_prev_q;
    // Fault tracking
    logic [3:0] ext_cnt_q;
    logic ext_fault_q;
    logic [STRINGS-1:0] string_off_q;
    logic short_latch_q;
    logic all_off_q;
    logic short_armed;
    logic [STRINGS-1:0] short_now;
    power_state_t state_q;
    logic run_gate;
    logic oe_n_d;
    logic [STRINGS-1:0] sink_enable_d;

    // Two-flop synchronisers for pin-level inputs
    // The fault line resets to its released (high) level so that leaving
    // reset never looks like a peer pulling the line low.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            en_s1_q <= 1'b0;
            en_q <= 1'b0;
            dim_s1_q <= 1'b0;
            dim_q <= 1'b0;
            fl_s1_q <= 1'b1;
            fl_q <= 1'b1;
            sh_s1_q <= '0;
            sh_q <= '0;
            rg_s1_q <= '0;
            rg_q <= '0;
        end else begin
            en_s1_q <= enable_pin;
            en_q <= en_s1_q;
            dim_s1_q <= dim_pulse_pin;
            dim_q <= dim_s1_q;
            fl_s1_q <= fault_line_in;
            fl_q <= fl_s1_q;
            sh_s1_q <= sink_sense.above_short;
            sh_q <= sh_s1_q;
            rg_s1_q <= sink_sense.in_regulation;
            rg_q <= rg_s1_q;
        end
    end

    // Counts clk edges with enable low; any high sample restarts it
    // RULE1: Enable low timer
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            en_low_cnt_q <= '0;
        // RULE11: Restart on high
        end else if (en_q) begin
            en_low_cnt_q <= '0;
        end else if (en_low_cnt_q != QUIET_LAST) begin
            en_low_cnt_q <= en_low_cnt_q + 1'b1;
        end
    end

    // Runs only while enable is high, so sleep and clear never race
    // RULE3: Dimming low timer while enabled
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            dim_low_cnt_q <= '0;
        // RULE11: Restart on high
        end else if (dim_q || !en_q) begin
            dim_low_cnt_q <= '0;
        end else if (dim_low_cnt_q != QUIET_LAST) begin
            dim_low_cnt_q <= dim_low_cnt_q + 1'b1;
        end
    end

    // All three pulses are combinational; every user of them is registered
    // Expiry pulses fire once as the counter reaches one below its last value
    assign sleep_evt = !en_q && (en_low_cnt_q == QUIET_LAST - 1'b1);
    assign clear_evt = en_q && !dim_q && (dim_low_cnt_q == QUIET_LAST - 1'b1);
    assign dim_rise = dim_q && !dim_prev_q;

    // Previous synchronised dimming level for the rise detector; it resets
    // low, the pin's idle level, so no false rise follows reset.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            dim_prev_q <= 1'b0;
        end else begin
            dim_prev_q <= dim_q;
        end
    end

    // Sleep wins over every other move, so a late dimming edge cannot
    // restart the converter while enable is already timing out.
    // Power state sequencing
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= ST_SLEEP;
        end else begin
            case (state_q)
                ST_SLEEP: begin
                    // Latches other than ext_fault_q are held clear for the whole sleep
                    // RULE2: Wake on enable
                    if (en_q) begin
                        state_q <= ST_IDLE;
                    end
                end
                ST_IDLE: begin
                    // RULE1: Sleep after quiet
                    if (sleep_evt) begin
                        state_q <= ST_SLEEP;
                    // RULE2: Soft start on dimming
                    end else if (en_q && dim_rise) begin
                        state_q <= ST_SOFT_START;
                    end
                end
                ST_SOFT_START: begin
                    // One cycle of soft-start request, then run
                    if (sleep_evt) begin
                        state_q <= ST_SLEEP;
                    end else begin
                        state_q <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (sleep_evt) begin
                        state_q <= ST_SLEEP;
                    // RULE3: Clear returns to idle
                    end else if (clear_evt) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: begin
                    // Unused codes fall back to the safe sleep state
                    state_q <= ST_SLEEP;
                end
            endcase
        end
    end

    // The count is held at zero while this block pulls the line itself:
    // its own pull-down must never read back as a peer's fault. It stops
    // one past the threshold, which is enough to set the latch.
    // RULE6: External fault low-time counter in switching cycles
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ext_cnt_q <= '0;
        end else if (fl_q || !fault_line_oe_n) begin
            ext_cnt_q <= '0;
        end else if (switch_tick && ext_cnt_q <= 4'(EXT_FAULT_SW_CYCLES)) begin
            ext_cnt_q <= ext_cnt_q + 1'b1;
        end
    end

    // Set wins over clear in the same cycle, as in every latch here
    // RULE6: Latch external all-off
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ext_fault_q <= 1'b0;
        end else if (ALL_OFF_VARIANT && ext_cnt_q > 4'(EXT_FAULT_SW_CYCLES)) begin
            ext_fault_q <= 1'b1;
        end else if (state_q == ST_SLEEP || clear_evt) begin
            ext_fault_q <= 1'b0;
        end
    end

    // With every sink above regulation the supply is simply too high for
    // the strings; detection stays off so that all channels keep running.
    // RULE10: Armed only while some sink regulates
    assign short_armed = |rg_q;
    // RULE7: Short compare per string while operating
    assign short_now = (state_q == ST_RUN && short_armed) ? sh_q : '0;

    // RULE8: Per-string disable latch, set wins over clear
    for (genvar s = 0; s < STRINGS; s++) begin : g_string
        // A string stays off once it showed a short, until the latches clear
        always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
                string_off_q[s] <= 1'b0;
            end else if (short_now[s]) begin
                string_off_q[s] <= 1'b1;
            end else if (state_q == ST_SLEEP || clear_evt) begin
                string_off_q[s] <= 1'b0;
            end
        end
    end

    // Standard variant: pull-down lasts until sleep or a dimming-low clear
    // RULE8: Fault indicator latch
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            short_latch_q <= 1'b0;
        end else if (|short_now) begin
            short_latch_q <= 1'b1;
        end else if (state_q == ST_SLEEP || clear_evt) begin
            short_latch_q <= 1'b0;
        end
    end

    // Any short in the all-off variant stops every string until cleared
    // RULE9: All-off latch on any short
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            all_off_q <= 1'b0;
        end else if (ALL_OFF_VARIANT && |short_now) begin
            all_off_q <= 1'b1;
        end else if (state_q == ST_SLEEP || clear_evt) begin
            all_off_q <= 1'b0;
        end
    end

    // Next values of the gated outputs
    always_comb begin
        run_gate = dim_q && !ext_fault_q && !all_off_q;
        // RULE5: Pull the line low while the short or all-off latch is set
        oe_n_d = !(short_latch_q || all_off_q);
        sink_enable_d = '0;
        // RULE9: Sinks gated by latches
        if (state_q == ST_RUN && run_gate) begin
            sink_enable_d = SINK_ALL_ON & ~string_off_q;
        end
    end

    // Every output comes straight from this register bank
    // Registered outputs
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            fault_line_out <= 1'b0;
            fault_line_oe_n <= 1'b1;
            bias_supply_on <= 1'b0;
            sync_clock_enable <= 1'b0;
            boost_enable <= 1'b0;
            soft_start_req <= 1'b0;
            sink_enable <= '0;
            power_state <= ST_SLEEP;
        end else begin
            fault_line_out <= 1'b0;
            // RULE5: Open-drain pull low on fault
            fault_line_oe_n <= oe_n_d;
            // Supplies stay on while enable is high, even across a fault clear
            // RULE4: Supplies follow enable
            bias_supply_on <= en_q || state_q != ST_SLEEP;
            sync_clock_enable <= en_q || state_q != ST_SLEEP;
            // RULE6: Boost off on all-off
            boost_enable <= (state_q == ST_RUN || state_q == ST_SOFT_START) && run_gate;
            // One-cycle request while passing through soft start
            soft_start_req <= (state_q == ST_SOFT_START);
            // RULE9: Sinks follow the gated next value
            sink_enable <= sink_enable_d;
            // State copy for the outside, one clock behind state_q
            power_state <= state_q;
        end
    end
endmodule // fault_shutdown

// [dv/fault_shutdown_properties.sv]
// Port checks for the fault supervisor
module fault_shutdown_properties #(
    parameter int unsigned QUIET_COUNT = 20,
    parameter bit ALL_OFF_VARIANT = 1'b0
) (
    // Watched ports
    input wire logic clk,
    input wire logic arst_n,
    input wire logic enable_pin,
    input wire logic dim_pulse_pin,
    input wire logic switch_tick,
    input wire fault_pkg::sink_sense_t sink_sense,
    input wire logic fault_line_in,
    input wire logic fault_line_out,
    input wire logic fault_line_oe_n,
    input wire logic bias_supply_on,
    input wire logic sync_clock_enable,
    input wire logic boost_enable,
    input wire logic soft_start_req,
    input wire logic [fault_pkg::STRINGS-1:0] sink_enable,
    input wire fault_pkg::power_state_t power_state
);
    timeunit 1ns;
    timeprecision 1ps;
    import fault_pkg::*;
    logic [31:0] en_lo_q;
    logic [31:0] dim_lo_q;
    logic [3:0] ext_q;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    // Quiet-time counters
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            en_lo_q <= '0;
            dim_lo_q <= '0;
        end else begin
            en_lo_q <= enable_pin ? '0 : en_lo_q + 1;
            dim_lo_q <= (dim_pulse_pin || !enable_pin) ? '0 : dim_lo_q + 1;
        end
    end
    // Ticks seen while a peer alone holds the line low
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) ext_q <= '0;
        else if (fault_line_in || !fault_line_oe_n) ext_q <= '0;
        else if (switch_tick && ext_q != 4'hf) ext_q <= ext_q + 4'h1;
    end
    property p_od; fault_line_out == 1'b0; endproperty
    a_od: assert property (p_od) else $error("fault line driven high");
    property p_bias; enable_pin [*8] |-> bias_supply_on && sync_clock_enable; endproperty
    a_bias: assert property (p_bias) else $error("bias off while enabled");
    property p_sleep; en_lo_q == QUIET_COUNT + 8 |-> power_state == ST_SLEEP; endproperty
    a_sleep: assert property (p_sleep) else $error("no sleep");
    property p_clear; dim_lo_q == QUIET_COUNT + 8 |-> fault_line_oe_n && bias_supply_on;
    endproperty
    a_clear: assert property (p_clear) else $error("fault not cleared");
    property p_soft; soft_start_req |-> dim_pulse_pin ##[1:4] boost_enable; endproperty
    a_soft: assert property (p_soft) else $error("bad soft start");
    property p_short;
        (power_state == ST_RUN && |sink_sense.in_regulation && |sink_sense.above_short) [*6]
        |-> !fault_line_oe_n;
    endproperty
    a_short: assert property (p_short) else $error("short not flagged");
    property p_ext; ALL_OFF_VARIANT && ext_q == 4'hc |-> !boost_enable && sink_enable == 6'h00;
    endproperty
    a_ext: assert property (p_ext) else $error("peer fault ignored");
    property p_slp; power_state == ST_SLEEP |-> !boost_enable && sink_enable == 6'h00;
    endproperty
    a_slp: assert property (p_slp) else $error("active in sleep");
    c_soft: cover property (soft_start_req);
    c_flt: cover property ($fell(fault_line_oe_n));
    c_ext: cover property (ext_q == 4'hc);
endmodule // fault_shutdown_properties

// [dv/fault_peer_model.sv]
// Peer driver on the shared fault line
module fault_peer_model (
    // Clock, tick and command
    input wire logic clk,
    input wire logic switch_tick,
    input wire logic go,
    input wire logic [7:0] hold_ticks,
    // Low while pulling the line
    output logic peer_oe_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] left_q = 8'h00;
    // Holds the line low for a set count of switching ticks
    always_ff @(posedge clk) begin
        if (go) left_q <= hold_ticks;
        else if (switch_tick && left_q != 8'h00) left_q <= left_q - 8'h01;
    end
    assign peer_oe_n = (left_q == 8'h00);
endmodule // fault_peer_model

// [dv/tb_led_driver_fault_shutdown_logic.sv]
// Self-checking bench for both fault supervisor variants
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin mismatches++; \
    $display("mismatch %s exp %0h got %0h", n, e, g); end end
module tb_led_driver_fault_shutdown_logic;
    timeunit 1ns;
    timeprecision 1ps;
    import fault_pkg::*;
    localparam int unsigned Q = 20;
    logic clk = 0, arst_n = 0, en = 0, dim = 0, go = 0, tick, peer_oe_n;
    logic [1:0] tick_q = 2'h0, oe_n, bias, boost, exp_oe;
    logic [7:0] hold = 8'h00;
    logic [5:0] sinks [2];
    sink_sense_t sense = '0;
    power_state_t st [2];
    int mismatches = 0, samples_checked = 0, seed = 83, k, exp_s [2];
    wire line = &oe_n & peer_oe_n;
    // Clock and a switching tick every four cycles
    always #10 clk = ~clk;
    always @(posedge clk) tick_q <= tick_q + 2'h1;
    assign tick = (tick_q == 2'h3);
    for (genvar v = 0; v < 2; v++) begin : g_dut
        fault_shutdown #(.QUIET_COUNT(Q), .ALL_OFF_VARIANT(v == 1)) fault_shutdown_inst (
            .clk(clk), .arst_n(arst_n), .enable_pin(en), .dim_pulse_pin(dim),
            .switch_tick(tick), .sink_sense(sense), .fault_line_in(line),
            .fault_line_out(), .fault_line_oe_n(oe_n[v]), .bias_supply_on(bias[v]),
            .sync_clock_enable(), .boost_enable(boost[v]), .soft_start_req(),
            .sink_enable(sinks[v]), .power_state(st[v]));
    end
    fault_peer_model fault_peer_model_inst (.clk(clk), .switch_tick(tick), .go(go),
        .hold_ticks(hold), .peer_oe_n(peer_oe_n));
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic wait_run(input int v);
        for (int i = 0; i < 40 && st[v] !== ST_RUN; i++) cyc(1);
        if (st[v] !== ST_RUN) begin
            mismatches++;
            stop_test();
        end
        cyc(4);
    endtask
    // Compare both variants with the reference outcome
    task automatic check_all(input string t);
        for (int v = 0; v < 2; v++) `CHK("sink_enable", exp_s[v][5:0], sinks[v])
        `CHK("fault_line_oe_n", exp_oe, oe_n)
        $display("test %s done", t);
        exp_s = '{'h3f, 'h3f};
        exp_oe = 2'h3;
    endtask
    initial begin
        cyc(16);
        arst_n = 1;
        exp_s = '{0, 0};
        exp_oe = 2'h3;
        check_all("reset");
        en = 1;
        cyc(6);
        dim = 1;
        sense.in_regulation = 6'h3f;
        wait_run(1);
        check_all("wake");
        k = {$random(seed)} % 6;
        sense = '{above_short: 6'h01 << k, in_regulation: ~(6'h01 << k)};
        cyc(12);
        sense.above_short = 6'h00;
        exp_s = '{'h3f & ~(1 << k), 0};
        exp_oe = 2'h0;
        check_all("short");
        dim = 0;
        cyc(Q - 6);
        dim = 1;
        cyc(3);
        dim = 0;
        cyc(Q - 6);
        `CHK("fault_line_oe_n", 2'h0, oe_n)
        cyc(16);
        `CHK("fault_line_oe_n", 2'h3, oe_n)
        `CHK("state", ST_IDLE, st[1])
        `CHK("bias", 2'h3, bias)
        dim = 1;
        wait_run(1);
        check_all("clear");
        sense = '{above_short: 6'($random(seed)) | 6'h01, in_regulation: 6'h00};
        cyc(12);
        sense = '{above_short: 6'h00, in_regulation: 6'h3f};
        check_all("noreg");
        // peer holds the line 7 then 12 ticks
        for (int n = 7; n < 13; n += 5) begin
            hold = 8'(n);
            go = 1;
            cyc(1);
            go = 0;
            cyc(42);
            if (n > 8) exp_s = '{'h3f, 0};
            check_all("peer");
        end
        `CHK("boost", 1'b0, boost[1])
        cyc(10);
        dim = 0;
        cyc(Q + 16);
        dim = 1;
        wait_run(1);
        sense = '{above_short: 6'h01, in_regulation: 6'h3e};
        cyc(12);
        sense = '{above_short: 6'h00, in_regulation: 6'h3f};
        en = 0;
        dim = 0;
        cyc(Q + 16);
        `CHK("state", ST_SLEEP, st[1])
        `CHK("bias", 2'h0, bias)
        en = 1;
        cyc(8);
        `CHK("fault_line_oe_n", 2'h3, oe_n)
        dim = 1;
        wait_run(1);
        check_all("sleep");
        stop_test();
    end
endmodule // tb_led_driver_fault_shutdown_logic
bind fault_shutdown fault_shutdown_properties #(.QUIET_COUNT(QUIET_COUNT),
    .ALL_OFF_VARIANT(ALL_OFF_VARIANT)) fault_shutdown_properties_inst (.*);
